// >>> inc/imms_pkg.sv
// package: constants and types for the indexer move mode sequencer
package imms_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // apb register map (byte addresses)
  localparam int unsigned IMMS_ADDR_W       = 8;
  localparam logic [7:0]  IMMS_OFS_CMD      = 8'h00;
  localparam logic [7:0]  IMMS_OFS_CTRL     = 8'h04;
  localparam logic [7:0]  IMMS_OFS_DISPLAY  = 8'h08;
  localparam logic [7:0]  IMMS_OFS_STATUS   = 8'h0C;
  localparam logic [7:0]  IMMS_OFS_POSITION = 8'h10;
  localparam logic [7:0]  IMMS_OFS_TARGET   = 8'h14;
  localparam logic [7:0]  IMMS_OFS_ACCEL    = 8'h18;
  localparam logic [7:0]  IMMS_OFS_VELOCITY = 8'h1C;
  localparam logic [7:0]  IMMS_OFS_DISTANCE = 8'h20;

  ////////////////////////////////////////////////////////////////////////////////
  // field layout
  localparam int unsigned IMMS_OP_W         = 4;
  localparam int unsigned IMMS_OP_LSB       = 0;
  localparam int unsigned IMMS_ARG_W        = 24;
  localparam int unsigned IMMS_ARG_LSB      = 8;
  localparam int unsigned IMMS_CTRL_KILL    = 0;
  localparam int unsigned IMMS_CTRL_RESUME  = 1;
  localparam int unsigned IMMS_CTRL_CLR_ERR = 2;
  localparam int unsigned IMMS_DISP_W       = 7;
  localparam int unsigned IMMS_PROF_W       = 16;
  localparam int unsigned IMMS_POS_W        = 32;
  localparam int unsigned IMMS_CHAR_W       = 8;

  ////////////////////////////////////////////////////////////////////////////////
  // values
  localparam logic [IMMS_DISP_W-1:0] IMMS_DISP_MAX    = 7'h63;
  localparam logic [IMMS_CHAR_W-1:0] IMMS_CHAR_LF     = 8'h0A;
  localparam logic [IMMS_POS_W-1:0]  IMMS_POS_ZERO    = 32'h0000_0000;
  localparam logic [IMMS_PROF_W-1:0] IMMS_ACCEL_RESET = 16'h0001;
  localparam logic [IMMS_PROF_W-1:0] IMMS_VEL_RESET   = 16'h0001;

  // buffered command codes
  typedef enum logic [IMMS_OP_W-1:0] {
    IMMS_OP_GO            = 4'h0,
    IMMS_OP_SEND_NEWLINE  = 4'h1,
    IMMS_OP_CONTINUOUS    = 4'h2,
    IMMS_OP_PRESET        = 4'h3,
    IMMS_OP_ABSOLUTE      = 4'h4,
    IMMS_OP_INCREMENTAL   = 4'h5,
    IMMS_OP_ZERO_POSITION = 4'h6,
    IMMS_OP_TRIGGER_WAIT  = 4'h7,
    IMMS_OP_PAUSE         = 4'h8,
    IMMS_OP_SET_DISTANCE  = 4'h9
  } imms_op_t;

  typedef struct packed {
    imms_op_t                op;
    logic [IMMS_ARG_W-1:0]   arg;
  } imms_cmd_t;

  typedef struct packed {
    logic                    start;
    logic                    continuous;
    logic [IMMS_POS_W-1:0]   target;
  } imms_move_t;

endpackage : imms_pkg

// >>> design/imms_sequencer.sv
// design: command queue, mode control, display and newline sender of the indexer
`timescale 1ns/1ps
`default_nettype none

module imms_sequencer
  import imms_pkg::*;
#(
  parameter int unsigned QUEUE_DEPTH = 16,
  parameter int unsigned TRIG_W      = 4
) (
  // clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [IMMS_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // motion profile generator
  output imms_move_t                  move_req,
  output logic      [IMMS_PROF_W-1:0] move_accel,
  output logic      [IMMS_PROF_W-1:0] move_velocity,
  output logic                        move_abort,
  input  wire logic                   move_done,
  input  wire logic                   motor_moving,
  // trigger inputs
  input  wire logic [TRIG_W-1:0]      trigger_in,
  // command link transmitter
  output logic                        tx_valid,
  output logic      [IMMS_CHAR_W-1:0] tx_char,
  input  wire logic                   tx_ready,
  // operator display
  output logic      [IMMS_DISP_W-1:0] display_value
);

  ////////////////////////////////////////////////////////////////////////////////
  // parameter checks
  if (QUEUE_DEPTH < 2 || QUEUE_DEPTH > 255) begin : g_bad_depth
    $error("QUEUE_DEPTH must lie between 2 and 255");
  end
  if (TRIG_W < 1 || TRIG_W > IMMS_ARG_W) begin : g_bad_trig
    $error("TRIG_W must lie between 1 and the argument width");
  end

  localparam int unsigned    PTR_W    = $clog2(QUEUE_DEPTH);
  localparam int unsigned    CNT_W    = $clog2(QUEUE_DEPTH + 1);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(QUEUE_DEPTH - 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(QUEUE_DEPTH);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_MOVE,
    ST_TRIGGER,
    ST_SEND
  } imms_state_t;

  ////////////////////////////////////////////////////////////////////////////////
  // state
  imms_cmd_t                   queue_mem [QUEUE_DEPTH];
  logic      [PTR_W-1:0]       wr_ptr;
  logic      [PTR_W-1:0]       rd_ptr;
  logic      [CNT_W-1:0]       q_count;
  imms_state_t                 state;
  logic                        cont_mode;
  logic                        abs_mode;
  logic                        paused;
  logic                        display_err;
  logic      [IMMS_POS_W-1:0]  position;
  logic      [IMMS_POS_W-1:0]  distance;
  logic      [TRIG_W-1:0]      trig_mask;

  ////////////////////////////////////////////////////////////////////////////////
  // apb decode
  wire logic                   setup_access = psel & penable & ~pready;
  wire logic                   apb_fire     = psel & penable & pready;
  wire logic                   wr_fire      = apb_fire & pwrite;
  wire logic                   hit_cmd      = paddr == IMMS_OFS_CMD;
  wire logic                   hit_ctrl     = paddr == IMMS_OFS_CTRL;
  wire logic                   hit_display  = paddr == IMMS_OFS_DISPLAY;
  wire logic                   hit_status   = paddr == IMMS_OFS_STATUS;
  wire logic                   hit_position = paddr == IMMS_OFS_POSITION;
  wire logic                   hit_target   = paddr == IMMS_OFS_TARGET;
  wire logic                   hit_accel    = paddr == IMMS_OFS_ACCEL;
  wire logic                   hit_velocity = paddr == IMMS_OFS_VELOCITY;
  wire logic                   hit_distance = paddr == IMMS_OFS_DISTANCE;
  wire logic                   hit_any      = hit_cmd | hit_ctrl | hit_display | hit_status
                                            | hit_position | hit_target | hit_accel
                                            | hit_velocity | hit_distance;
  wire logic [IMMS_OP_W-1:0]   wr_op        = pwdata[IMMS_OP_LSB +: IMMS_OP_W];
  wire logic [IMMS_DISP_W-1:0] wr_disp      = pwdata[IMMS_DISP_W-1:0];
  wire logic                   q_full       = q_count == CNT_FULL;
  wire logic                   op_bad       = wr_op > IMMS_OP_SET_DISTANCE;
  wire logic                   disp_bad     = (pwdata[31:IMMS_DISP_W] != '0)
                                            | (wr_disp > IMMS_DISP_MAX);
  wire logic                   next_err     = ~hit_any
                                            | (pwrite & hit_cmd & (q_full | op_bad))
                                            | (pwrite & hit_display & disp_bad);
  wire logic                   kill         = wr_fire & hit_ctrl & pwdata[IMMS_CTRL_KILL];
  wire logic                   resume       = wr_fire & hit_ctrl & pwdata[IMMS_CTRL_RESUME];
  wire logic                   clr_err      = wr_fire & hit_ctrl & pwdata[IMMS_CTRL_CLR_ERR];
  wire logic                   push         = wr_fire & hit_cmd & ~pslverr & ~kill;
  wire logic                   disp_wr      = wr_fire & hit_display;

  wire logic [31:0] status_word = {{(24 - CNT_W){1'b0}}, q_count, 1'b0, q_full, display_err,
                                   motor_moving, paused, abs_mode, cont_mode,
                                   state != ST_IDLE};
  wire logic [31:0] next_rdata  =
      hit_display  ? {{(32 - IMMS_DISP_W){1'b0}}, display_value} :
      hit_status   ? status_word :
      hit_position ? position :
      hit_target   ? move_req.target :
      hit_accel    ? {{(32 - IMMS_PROF_W){1'b0}}, move_accel} :
      hit_velocity ? {{(32 - IMMS_PROF_W){1'b0}}, move_velocity} :
      hit_distance ? distance : 32'h0000_0000;

  // one-wait transfer: pready rises in the second access cycle, data and error with it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup_access;
      pslverr <= setup_access & next_err;
      prdata  <= (setup_access & ~pwrite & ~next_err) ? next_rdata : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // command queue
  imms_cmd_t                   head;
  wire logic                   pop        = (state == ST_IDLE) & (q_count != '0)
                                          & ~paused & ~kill;
  wire logic [PTR_W-1:0]       next_wr    = (wr_ptr == PTR_LAST) ? '0 : wr_ptr + 1'b1;
  wire logic [PTR_W-1:0]       next_rd    = (rd_ptr == PTR_LAST) ? '0 : rd_ptr + 1'b1;
  assign head = queue_mem[rd_ptr];

  always_ff @(posedge pclk) begin
    if (push) begin
      queue_mem[wr_ptr] <= {imms_op_t'(wr_op), pwdata[IMMS_ARG_LSB +: IMMS_ARG_W]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr  <= '0;
      rd_ptr  <= '0;
      q_count <= '0;
    end else if (kill) begin
      wr_ptr  <= '0;
      rd_ptr  <= '0;
      q_count <= '0;
    end else begin
      if (push) wr_ptr <= next_wr;
      if (pop) rd_ptr <= next_rd;
      q_count <= q_count + CNT_W'(push) - CNT_W'(pop);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // decoded head command
  wire logic                   at_rest    = ~motor_moving;
  wire logic [IMMS_POS_W-1:0]  arg_sext   = {{(IMMS_POS_W - IMMS_ARG_W){head.arg[IMMS_ARG_W-1]}},
                                             head.arg};
  wire logic [IMMS_POS_W-1:0]  go_target  = abs_mode ? distance : position + distance;
  wire logic                   go_still   = ~cont_mode & (go_target == position);
  wire logic                   do_go      = pop & (head.op == IMMS_OP_GO);
  wire logic                   do_newline = pop & (head.op == IMMS_OP_SEND_NEWLINE);
  wire logic                   do_trigger = pop & (head.op == IMMS_OP_TRIGGER_WAIT);
  wire logic                   do_zero    = pop & (head.op == IMMS_OP_ZERO_POSITION);
  wire logic                   trig_met   = (trigger_in & trig_mask) == trig_mask;
  wire logic                   tx_taken   = tx_valid & tx_ready;

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
    end else if (kill) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (do_go && !go_still) state <= ST_MOVE;
          else if (do_trigger) state <= ST_TRIGGER;
          else if (do_newline) state <= ST_SEND;
        end
        ST_MOVE: begin
          if (move_done) state <= ST_IDLE;
        end
        ST_TRIGGER: begin
          if (trig_met) state <= ST_IDLE;
        end
        ST_SEND: begin
          if (tx_taken) state <= ST_IDLE;
        end
      endcase
    end
  end

  // modes, pause and programmed distance
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cont_mode <= 1'b0;
      abs_mode  <= 1'b0;
      paused    <= 1'b0;
      distance  <= IMMS_POS_ZERO;
      trig_mask <= '0;
    end else if (kill) begin
      paused    <= 1'b0;
    end else if (pop) begin
      unique case (head.op)
        IMMS_OP_CONTINUOUS:   if (at_rest) cont_mode <= 1'b1;
        IMMS_OP_PRESET:       if (at_rest) cont_mode <= 1'b0;
        IMMS_OP_ABSOLUTE:     abs_mode  <= 1'b1;
        IMMS_OP_INCREMENTAL:  abs_mode  <= 1'b0;
        IMMS_OP_PAUSE:        paused    <= 1'b1;
        IMMS_OP_SET_DISTANCE: distance  <= arg_sext;
        IMMS_OP_TRIGGER_WAIT: trig_mask <= head.arg[TRIG_W-1:0];
        default:              ;
      endcase
    end else if (resume) begin
      paused <= 1'b0;
    end
  end

  // position counter follows each completed preset move
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      position <= IMMS_POS_ZERO;
    end else if (do_zero) begin
      position <= IMMS_POS_ZERO;
    end else if (state == ST_MOVE && move_done && !move_req.continuous && !kill) begin
      position <= move_req.target;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // motion request, link and display outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      move_req   <= '0;
      move_abort <= 1'b0;
    end else begin
      move_abort     <= kill;
      move_req.start <= do_go & ~go_still & ~kill;
      if (do_go && !go_still) begin
        move_req.continuous <= cont_mode;
        move_req.target     <= cont_mode ? position : go_target;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      move_accel    <= IMMS_ACCEL_RESET;
      move_velocity <= IMMS_VEL_RESET;
    end else begin
      if (wr_fire && hit_accel) move_accel <= pwdata[IMMS_PROF_W-1:0];
      if (wr_fire && hit_velocity) move_velocity <= pwdata[IMMS_PROF_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_valid <= 1'b0;
      tx_char  <= IMMS_CHAR_LF;
    end else if (kill) begin
      tx_valid <= 1'b0;
    end else if (do_newline) begin
      tx_valid <= 1'b1;
      tx_char  <= IMMS_CHAR_LF;
    end else if (tx_taken) begin
      tx_valid <= 1'b0;
    end
  end

  // refused display values raise a sticky flag; a new refusal beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      display_value <= '0;
      display_err   <= 1'b0;
    end else begin
      if (disp_wr && !pslverr) display_value <= wr_disp;
      if (disp_wr && pslverr) display_err <= 1'b1;
      else if (clr_err) display_err <= 1'b0;
    end
  end

endmodule : imms_sequencer

`default_nettype wire

// >>> testbench/imms_properties.sv
// checker: port properties of the sequencer
`timescale 1ns/1ps
`default_nettype none
module imms_checker
  import imms_pkg::*;
(
  // clock and reset
  input wire logic                   pclk,
  input wire logic                   presetn,
  // apb
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [IMMS_ADDR_W-1:0] paddr,
  input wire logic [31:0]            pwdata,
  input wire logic                   pready,
  // motion, link and display
  input wire imms_move_t             move_req,
  input wire logic                   move_abort,
  input wire logic                   motor_moving,
  input wire logic                   tx_valid,
  input wire logic [IMMS_CHAR_W-1:0] tx_char,
  input wire logic                   tx_ready,
  input wire logic [IMMS_DISP_W-1:0] display_value
);
  wire logic wr_done  = psel & penable & pready & pwrite;
  wire logic kill_wr  = wr_done && paddr == IMMS_OFS_CTRL && pwdata[IMMS_CTRL_KILL];
  wire logic disp_wr  = wr_done && paddr == IMMS_OFS_DISPLAY;
  wire logic disp_ok  = disp_wr && pwdata <= 32'h0000_0063;
  wire logic disp_bad = disp_wr && pwdata > 32'h0000_0063;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  apb_one_wait_a: assert property (psel && !penable |-> !pready ##2 pready)
    else $error("apb answer not after one wait state");
  pready_pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  char_code_a: assert property (tx_char == IMMS_CHAR_LF) else $error("link char wrong");
  disp_range_a: assert property (display_value <= IMMS_DISP_MAX)
    else $error("display out of range");
  disp_load_a: assert property (disp_ok |=> display_value == $past(pwdata[6:0]))
    else $error("display not loaded");
  disp_refuse_a: assert property (disp_bad |=> $stable(display_value))
    else $error("display took bad value");
  tx_hold_a: assert property (tx_valid && !tx_ready && !kill_wr |=> tx_valid)
    else $error("char dropped before accept");
  kill_flush_a: assert property (kill_wr |=> move_abort && !tx_valid ##1 !move_abort)
    else $error("kill did not abort");
  lf_after_move_a: assert property ($rose(tx_valid) |-> !motor_moving)
    else $error("char sent during move");
  start_pulse_a: assert property (move_req.start |=> !move_req.start) else $error("start too long");
  cover property (kill_wr);
  cover property (tx_valid && tx_ready);
  cover property (move_req.start && move_req.continuous);
endmodule : imms_checker
bind imms_sequencer imms_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .move_req(move_req), .move_abort(move_abort), .motor_moving(motor_moving),
  .tx_valid(tx_valid), .tx_char(tx_char), .tx_ready(tx_ready), .display_value(display_value));
`default_nettype wire

// >>> testbench/imms_partner.sv
// partner: profile generator and link receiver facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module imms_partner
  import imms_pkg::*;
(
  // clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // profile generator
  input  wire imms_move_t             move_req,
  input  wire logic                   move_abort,
  output logic                        move_done,
  output logic                        motor_moving,
  // link receiver
  input  wire logic                   tx_valid,
  input  wire logic [IMMS_CHAR_W-1:0] tx_char,
  output logic                        tx_ready,
  // test control and counters
  input  wire logic                   slow,
  output logic      [7:0]             lf_count,
  output logic      [7:0]             start_count
);
  logic [7:0] left;
  logic       cont;
  logic [1:0] ph;
  // a slow receiver only accepts one cycle in four
  assign tx_ready = !slow || ph == 2'd3;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {move_done, motor_moving, cont, left, ph, lf_count, start_count} <= '0;
    end else begin
      move_done <= 1'b0;
      ph        <= ph + 2'd1;
      if (tx_valid && tx_ready && tx_char == IMMS_CHAR_LF) lf_count <= lf_count + 8'd1;
      if (move_req.start) begin
        motor_moving <= 1'b1;
        cont         <= move_req.continuous;
        left         <= slow ? 8'd40 : 8'd3;
        start_count  <= start_count + 8'd1;
      end else if (move_abort) begin
        // deceleration keeps the motor turning a while after a kill
        cont <= 1'b0;
        left <= 8'd12;
      end else if (motor_moving && !cont) begin
        left <= left - 8'd1;
        if (left == 8'd0) begin
          motor_moving <= 1'b0;
          move_done    <= 1'b1;
        end
      end
    end
  end
endmodule : imms_partner
`default_nettype wire

// >>> testbench/test_indexer_move_mode_sequencer.sv
// testbench: self-checking scenarios for the sequencer
`timescale 1ns/1ps
`default_nettype none
module test_indexer_move_mode_sequencer
  import imms_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, se, slow;
  logic move_abort, move_done, motor_moving, tx_valid, tx_ready;
  logic [IMMS_ADDR_W-1:0] paddr;
  logic [31:0]            pwdata, prdata, rd;
  imms_move_t             move_req;
  logic [IMMS_PROF_W-1:0] move_accel, move_velocity;
  logic [3:0]             trigger_in;
  logic [IMMS_CHAR_W-1:0] tx_char;
  logic [IMMS_DISP_W-1:0] display_value;
  logic [7:0]             lf_count, start_count, lf0, st0;
  int                     err_total, num_checks, cycles;
  imms_sequencer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .move_req(move_req), .move_accel(move_accel),
    .move_velocity(move_velocity), .move_abort(move_abort), .move_done(move_done),
    .motor_moving(motor_moving), .trigger_in(trigger_in), .tx_valid(tx_valid),
    .tx_char(tx_char), .tx_ready(tx_ready), .display_value(display_value));
  imms_partner u_far (.pclk(pclk), .presetn(presetn), .move_req(move_req),
    .move_abort(move_abort), .move_done(move_done), .motor_moving(motor_moving),
    .tx_valid(tx_valid), .tx_char(tx_char), .tx_ready(tx_ready), .slow(slow),
    .lf_count(lf_count), .start_count(start_count));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task complete_run();
    if (err_total == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task cmd(input logic [3:0] op, input logic [23:0] arg);
    apb(1'b1, IMMS_OFS_CMD, {arg, 4'h0, op});
  endtask : cmd
  task wait_idle();
    // idle means nothing left queued as well, since the sequencer shows idle for a cycle after each move, wait or send before the next pop
    do apb(1'b0, IMMS_OFS_STATUS, 32'h0);
    while (rd[0] !== 1'b0 || rd[4] !== 1'b0 || rd[15:8] !== 8'h00);
  endtask : wait_idle
  ////////////////////////////////////////////////////////////////////////////////
  task t_reset();
    apb(1'b0, IMMS_OFS_ACCEL, 32'h0);
    chk(rd, 32'h0000_0001, "accel reset");
    apb(1'b1, IMMS_OFS_VELOCITY, 32'h0000_1234);
    chk({16'h0, move_velocity}, 32'h0000_1234, "velocity out");
    apb(1'b0, IMMS_OFS_POSITION, 32'h0);
    chk(rd, IMMS_POS_ZERO, "position reset");
  endtask : t_reset
  task t_display();
    apb(1'b1, IMMS_OFS_DISPLAY, 32'h0000_0063);
    chk({25'h0, display_value}, 32'h0000_0063, "display 99");
    apb(1'b1, IMMS_OFS_DISPLAY, 32'h0000_0064);
    chk({se, 24'h0, display_value}, 32'h8000_0063, "display 100 kept");
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, se}, 32'h1, "unmapped read");
  endtask : t_display
  task t_incremental();
    slow <= 1'b1;
    cmd(4'h9, 24'd40);
    cmd(4'h0, 24'd0);
    cmd(4'h1, 24'd0);
    cmd(4'h0, 24'd0);
    wait_idle();
    apb(1'b0, IMMS_OFS_POSITION, 32'h0);
    chk(rd, 32'h0000_0050, "two relative moves");
    chk({lf_count, start_count}, {lf0 + 8'd1, st0 + 8'd2}, "queued newline");
    slow <= 1'b0;
  endtask : t_incremental
  task t_absolute();
    cmd(4'h4, 24'd0);
    cmd(4'h9, 24'd24);
    cmd(4'h0, 24'd0);
    cmd(4'h0, 24'd0);
    wait_idle();
    apb(1'b0, IMMS_OFS_POSITION, 32'h0);
    chk(rd, 32'h0000_0018, "absolute target");
    chk(move_req.target, 32'h0000_0018, "absolute target out");
    chk({24'h0, start_count}, {24'h0, st0 + 8'd3}, "second go still");
    cmd(4'h6, 24'd0);
    cmd(4'h5, 24'd0);
    wait_idle();
    apb(1'b0, IMMS_OFS_POSITION, 32'h0);
    chk(rd, IMMS_POS_ZERO, "zeroed");
  endtask : t_absolute
  task t_trigger();
    trigger_in <= 4'h1;
    cmd(4'h7, 24'd3);
    cmd(4'h1, 24'd0);
    repeat (20) @(posedge pclk);
    chk({24'h0, lf_count}, {24'h0, lf0 + 8'd1}, "newline held");
    trigger_in <= 4'h3;
    wait_idle();
    chk({24'h0, lf_count}, {24'h0, lf0 + 8'd2}, "newline on trigger");
  endtask : t_trigger
  task t_continuous();
    cmd(4'h2, 24'd0);
    cmd(4'h0, 24'd0);
    cmd(4'h1, 24'd0);
    apb(1'b0, IMMS_OFS_STATUS, 32'h0);
    chk({31'h0, move_req.continuous}, 32'h1, "endless move");
    chk({31'h0, rd[1]}, 32'h1, "continuous at rest");
    apb(1'b1, IMMS_OFS_CTRL, 32'h0000_0001);
    cmd(4'h3, 24'd0);
    wait_idle();
    chk({31'h0, rd[1]}, 32'h1, "preset while moving");
    chk({24'h0, lf_count}, {24'h0, lf0 + 8'd2}, "flushed newline");
    cmd(4'h3, 24'd0);
    wait_idle();
    chk({31'h0, rd[1]}, 32'h0, "preset at rest");
    cmd(4'h8, 24'd0);
    cmd(4'h1, 24'd0);
    repeat (20) @(posedge pclk);
    apb(1'b0, IMMS_OFS_STATUS, 32'h0);
    chk({lf_count, 7'h0, rd[3]}, {lf0 + 8'd2, 8'h01}, "paused newline held");
    apb(1'b1, IMMS_OFS_CTRL, 32'h0000_0002);
    wait_idle();
    chk({lf_count, 7'h0, rd[3]}, {lf0 + 8'd3, 8'h00}, "newline after resume");
  endtask : t_continuous
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {presetn, psel, penable, pwrite, slow, paddr, pwdata, trigger_in} = '0;
    {err_total, num_checks, cycles} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    lf0 = 8'd0;
    st0 = 8'd0;
    t_reset();
    t_display();
    t_incremental();
    t_absolute();
    t_trigger();
    t_continuous();
    complete_run();
  end
endmodule : test_indexer_move_mode_sequencer
`default_nettype wire
